// [verilog/tcc_device.sv]
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module tcc_device
(
    input wire logic clk_i,
    input wire logic rst_i,
    tcc_if.dev bus,
    input wire logic [tcc_pkg::NUM_CNT-1:0] src_i,
    input wire logic [tcc_pkg::NUM_CNT-1:0] gate_i,
    output logic divided_freq_output_o,
    output logic [tcc_pkg::NUM_CNT-1:0] tc_o,
    output logic prefetch_wr_o
);
    import tcc_pkg::*;
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // a bit changes only once stages two and three agree
    logic [2*NUM_CNT-1:0] s1_reg;
    logic [2*NUM_CNT-1:0] s2_reg;
    logic [2*NUM_CNT-1:0] s3_reg;
    logic [2*NUM_CNT-1:0] pin_reg;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            pin_reg <= '0;
        end
        else
        begin
            s1_reg <= {gate_i, src_i};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg | s3_reg));
        end
    end
    wire [NUM_CNT-1:0] src_f = pin_reg[NUM_CNT-1:0];
    wire [NUM_CNT-1:0] gate_f = pin_reg[2*NUM_CNT-1:NUM_CNT];
    // ----------------------------------------
    // internal frequency taps
    // ----------------------------------------
    logic [PRE_W-1:0] pre_reg;
    logic [NUM_CNT-1:0] internal_freq_taps;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            pre_reg <= '0;
        else
            pre_reg <= pre_reg + 1'b1;
    end
    genvar t;
    generate
        for (t = 0; t < NUM_CNT; t++)
        begin : g_tap
            assign internal_freq_taps[t] = pre_reg[TAP_STEP*t];
        end
    endgenerate
    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic [7:0] busy_cnt_reg;
    logic busy_reg;
    logic pf_wr_reg;
    logic [4:0] dp_reg;
    logic [15:0] mm_reg;
    logic [15:0] rdata_reg;
    logic fdiv_reg;
    logic [3:0] fcnt_reg;
    logic fprev_reg;
    logic divided_freq_output_reg;
    logic [15:0] mode_reg [NUM_CNT];
    logic [15:0] load_reg [NUM_CNT];
    logic [15:0] hold_reg [NUM_CNT];
    logic [15:0] count_w [NUM_CNT];
    logic [NUM_CNT-1:0] tc_w;
    // writes arriving during recovery are dropped; the host must watch busy
    wire take = bus.wr & ~busy_reg;
    wire cmd_wr = take & bus.cd;
    wire data_wr = take & ~bus.cd;
    wire [7:0] op = bus.wdata[7:0];
    wire [2:0] op_grp = op[7:5];
    wire mreset = cmd_wr & (op == OP_MRESET);
    wire gate_on = cmd_wr & (op == OP_GATE_ON);
    wire gate_off = cmd_wr & (op == OP_GATE_OFF);
    wire pf_dis = cmd_wr & (op == OP_PF_DIS);
    wire pf_en = cmd_wr & (op == OP_PF_EN);
    wire [NUM_CNT-1:0] sel_s = op[NUM_CNT-1:0];
    wire [NUM_CNT-1:0] load_v = (cmd_wr & (op_grp == CG_LOAD)) ? sel_s : '0;
    wire [NUM_CNT-1:0] arm_v = (cmd_wr & (op_grp == CG_ARM)) ? sel_s : '0;
    wire [NUM_CNT-1:0] save_v = (cmd_wr & (op_grp == CG_SAVE)) ? sel_s : '0;
    wire [NUM_CNT-1:0] disarm_v = (cmd_wr & (op_grp == CG_DISARM)) ? sel_s : '0;
    wire ptr_ok = (op[2:0] != 3'h0) & (op[2:0] != DP_G_BAD);
    wire ptr_wr = cmd_wr & (op_grp == CG_PTR) & ptr_ok;
    // ----------------------------------------
    // data pointer target
    // ----------------------------------------
    wire [2:0] dp_g = dp_reg[2:0];
    wire [1:0] dp_e = dp_reg[4:3];
    wire [2:0] dp_idx = dp_g - 3'h1;
    wire dp_cnt = (dp_g != 3'h0) & (dp_g <= 3'(NUM_CNT));
    wire dp_master = (dp_g == DP_G_MASTER);
    wire [15:0] pointed = dp_master ? mm_reg :
                          ~dp_cnt ? 16'h0000 :
                          (dp_e == DP_E_MODE) ? mode_reg[dp_idx] :
                          (dp_e == DP_E_LOAD) ? load_reg[dp_idx] : hold_reg[dp_idx];
    wire [15:0] status = 16'(tc_w) << STAT_TC_LSB;
    wire [7:0] rec_cyc = cmd_wr ? CMD_REC_CYC :
                         (pf_wr_reg ? DW_REC_PF_CYC : DW_REC_NPF_CYC);
    wire [7:0] busy_next = take ? rec_cyc :
                           ((busy_cnt_reg != 8'h00) ? busy_cnt_reg - 8'h01 : 8'h00);
    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // the data pointer survives the reset command; only the pin reset clears it
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            dp_reg <= 5'h00;
        else if (ptr_wr)
            dp_reg <= op[4:0];
    end
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mm_reg <= MM_RST;
            pf_wr_reg <= 1'b1;
            busy_cnt_reg <= 8'h00;
            busy_reg <= 1'b0;
        end
        else
        begin
            busy_cnt_reg <= busy_next;
            busy_reg <= (busy_next != 8'h00);
            if (mreset)
            begin
                mm_reg <= MM_RST;
                pf_wr_reg <= 1'b1;
            end
            else
            begin
                if (gate_on)
                    mm_reg[MM_FGATE_BIT] <= 1'b0;
                else if (gate_off)
                    mm_reg[MM_FGATE_BIT] <= 1'b1;
                else if (data_wr & dp_master)
                    mm_reg <= bus.wdata;
                if (pf_dis)
                    pf_wr_reg <= 1'b0;
                else if (pf_en)
                    pf_wr_reg <= 1'b1;
            end
        end
    end
    // ----------------------------------------
    // counters
    // ----------------------------------------
    genvar k;
    generate
        for (k = 0; k < NUM_CNT; k++)
        begin : g_cnt
            wire hit = data_wr & dp_cnt & (dp_idx == 3'(k));
            always_ff @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    mode_reg[k] <= CM_RST;
                    load_reg[k] <= LD_RST;
                    hold_reg[k] <= LD_RST;
                end
                else if (mreset)
                begin
                    mode_reg[k] <= CM_RST;
                    load_reg[k] <= LD_RST;
                    hold_reg[k] <= LD_RST;
                end
                else
                begin
                    if (hit & (dp_e == DP_E_MODE))
                        mode_reg[k] <= bus.wdata;
                    if (hit & (dp_e == DP_E_LOAD))
                        load_reg[k] <= bus.wdata;
                    if (save_v[k])
                        hold_reg[k] <= count_w[k];
                    else if (hit & (dp_e > DP_E_LOAD))
                        hold_reg[k] <= bus.wdata;
                end
            end
            tcc_counter u_cnt (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .clear_i(mreset),
                .mode_i(mode_reg[k]),
                .load_i(load_reg[k]),
                .load_cmd_i(load_v[k]),
                .arm_cmd_i(arm_v[k]),
                .disarm_cmd_i(disarm_v[k]),
                .src_all_i({internal_freq_taps, gate_f, src_f, tc_w[(k+NUM_CNT-1)%NUM_CNT]}),
                .own_gate_i(gate_f[k]),
                .count_o(count_w[k]),
                .tc_o(tc_w[k])
            );
        end
    endgenerate
    // ----------------------------------------
    // read path
    // ----------------------------------------
    // data reads take the word the pointer selects, status reads take the status; both are frozen at the read edge
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_reg <= 16'h0000;
        else if (bus.rd)
            rdata_reg <= bus.cd ? status : pointed;
    end
    // ----------------------------------------
    // frequency output
    // ----------------------------------------
    wire [15:0] f_all = {internal_freq_taps, gate_f, src_f, 1'b0};
    wire f_lvl = f_all[mm_reg[MM_FSRC_LSB +: 4]];
    wire f_edge = f_lvl & ~fprev_reg;
    wire [3:0] f_div = mm_reg[MM_FDIV_LSB +: 4];
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fprev_reg <= 1'b0;
            fcnt_reg <= 4'h0;
            fdiv_reg <= 1'b0;
            divided_freq_output_reg <= 1'b0;
        end
        else
        begin
            fprev_reg <= f_lvl;
            if (f_edge & (fcnt_reg == f_div - 4'h1))
            begin
                fcnt_reg <= 4'h0;
                fdiv_reg <= ~fdiv_reg;
            end
            else if (f_edge)
                fcnt_reg <= fcnt_reg + 4'h1;
            // switching the gate may cut a half period short
            divided_freq_output_reg <= mm_reg[MM_FGATE_BIT] ? 1'b0 : fdiv_reg;
        end
    end
    assign divided_freq_output_o = divided_freq_output_reg;
    assign tc_o = tc_w;
    assign prefetch_wr_o = pf_wr_reg;
    assign bus.rdata = rdata_reg;
    assign bus.busy = busy_reg;
endmodule

// [inc/tcc_pkg.sv]
package tcc_pkg;
    localparam int NUM_CNT = 5;
    localparam int PRE_W = 17;
    localparam int TAP_STEP = 4;
    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_GATE_ON = 8'hE6;
    localparam logic [7:0] OP_GATE_OFF = 8'hEE;
    localparam logic [7:0] OP_PF_DIS = 8'hF9;
    localparam logic [7:0] OP_PF_EN = 8'hF8;
    localparam logic [7:0] OP_MRESET = 8'hFF;
    localparam logic [7:0] OP_LOAD_ALL = 8'h5F;
    localparam logic [7:0] OP_INIT_DP = 8'h01;
    localparam logic [2:0] CG_PTR = 3'h0;
    localparam logic [2:0] CG_ARM = 3'h1;
    localparam logic [2:0] CG_LOAD = 3'h2;
    localparam logic [2:0] CG_SAVE = 3'h5;
    localparam logic [2:0] CG_DISARM = 3'h6;
    localparam logic [2:0] DP_G_BAD = 3'h6;
    localparam logic [2:0] DP_G_MASTER = 3'h7;
    localparam logic [1:0] DP_E_MODE = 2'h0;
    localparam logic [1:0] DP_E_LOAD = 2'h1;
    // ----------------------------------------
    // register fields and reset values
    // ----------------------------------------
    localparam int MM_FGATE_BIT = 12;
    localparam int MM_FDIV_LSB = 8;
    localparam int MM_FSRC_LSB = 4;
    localparam int CM_GC_LSB = 13;
    localparam int CM_EDGE_BIT = 12;
    localparam int CM_SRC_LSB = 8;
    localparam int CM_SG_BIT = 7;
    localparam int STAT_TC_LSB = 1;
    localparam logic [15:0] MM_RST = 16'h0000;
    localparam logic [15:0] LD_RST = 16'h0000;
    localparam logic [15:0] CM_RST = 16'h0B00;
    localparam logic [2:0] GC_EDGE_HI = 3'h6;
    localparam logic [2:0] GC_EDGE_LO = 3'h7;
    localparam logic [2:0] GC_LEVEL_LO = 3'h5;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 25;
    localparam int CMD_REC_NS = 1000;
    localparam int DW_REC_PF_NS = 1500;
    localparam int DW_REC_NPF_NS = 1000;
    localparam logic [7:0] CMD_REC_CYC = 8'((CMD_REC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] DW_REC_PF_CYC = 8'((DW_REC_PF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] DW_REC_NPF_CYC = 8'((DW_REC_NPF_NS + CLK_NS - 1) / CLK_NS);
    // ----------------------------------------
    // host register map
    // ----------------------------------------
    localparam logic [7:0] HR_CMD = 8'h00;
    localparam logic [7:0] HR_DATA = 8'h04;
    localparam logic [7:0] HR_READ = 8'h08;
    localparam logic [7:0] HR_INIT = 8'h0C;
    localparam logic [7:0] HR_STATUS = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [inc/tcc_if.sv]
`timescale 1ns/10ps
interface tcc_if;
    logic cd;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic busy;
    modport dev (input cd, input wr, input rd, input wdata, output rdata, output busy);
    modport host (output cd, output wr, output rd, output wdata, input rdata, input busy);
endinterface

// [verilog/tcc_counter.sv]
`timescale 1ns/10ps
module tcc_counter
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic [15:0] mode_i,
    input wire logic [15:0] load_i,
    input wire logic load_cmd_i,
    input wire logic arm_cmd_i,
    input wire logic disarm_cmd_i,
    input wire logic [15:0] src_all_i,
    input wire logic own_gate_i,
    output logic [15:0] count_o,
    output logic tc_o
);
    import tcc_pkg::*;
    logic [15:0] count_reg;
    logic tc_reg;
    logic armed_reg;
    logic run_reg;
    logic lvl_prev_reg;
    logic gate_prev_reg;
    wire [3:0] src_sel = mode_i[CM_SRC_LSB +: 4];
    wire [2:0] gc = mode_i[CM_GC_LSB +: 3];
    wire sg = mode_i[CM_SG_BIT];
    wire lvl = src_all_i[src_sel] ^ mode_i[CM_EDGE_BIT];
    wire src_edge = lvl & ~lvl_prev_reg;
    wire gate_act = own_gate_i ^ ((gc == GC_LEVEL_LO) | (gc == GC_EDGE_LO));
    wire gate_rise = gate_act & ~gate_prev_reg;
    wire edge_gating = ~sg & ((gc == GC_EDGE_HI) | (gc == GC_EDGE_LO));
    wire retrig = sg & (gc != 3'h0) & gate_rise;
    wire level_gating = ~sg & (gc != 3'h0) & ~edge_gating;
    wire count_ok = edge_gating ? run_reg : (level_gating ? gate_act : 1'b1);
    wire step = armed_reg & src_edge & count_ok;
    assign count_o = count_reg;
    assign tc_o = tc_reg;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lvl_prev_reg <= 1'b0;
            gate_prev_reg <= 1'b0;
        end
        else
        begin
            lvl_prev_reg <= lvl;
            gate_prev_reg <= gate_act;
        end
    end
    // a load in the same cycle as a source edge wins: the edge counts as earlier
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            count_reg <= 16'h0000;
            tc_reg <= 1'b0;
            armed_reg <= 1'b0;
            run_reg <= 1'b0;
        end
        else if (clear_i)
        begin
            count_reg <= 16'h0000;
            tc_reg <= 1'b0;
            armed_reg <= 1'b0;
            run_reg <= 1'b0;
        end
        else
        begin
            if (arm_cmd_i)
                armed_reg <= 1'b1;
            else if (disarm_cmd_i)
                armed_reg <= 1'b0;
            if (edge_gating & gate_rise)
                run_reg <= 1'b1;
            else if (step & (count_reg == 16'h0001))
                run_reg <= 1'b0;
            if (load_cmd_i | retrig)
            begin
                count_reg <= load_i;
                tc_reg <= 1'b0;
            end
            else if (step & tc_reg)
            begin
                count_reg <= load_i;
                tc_reg <= 1'b0;
            end
            else if (step)
            begin
                count_reg <= count_reg - 16'h0001;
                tc_reg <= (count_reg == 16'h0001);
            end
        end
    end
endmodule

// [verilog/tcc_host.sv]
`timescale 1ns/10ps
module tcc_host
(
    input wire logic clk_i,
    input wire logic rst_i,
    tcc_if.host bus,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import tcc_pkg::*;
    typedef enum logic [2:0] {H_IDLE, H_WRITE, H_WAIT, H_READ, H_RGAP, H_INIT} tcc_hst_t;
    tcc_hst_t st_reg;
    logic cd_reg, wr_reg, rd_reg, init_act_reg, init_done_reg;
    logic [15:0] wd_reg, last_rd_reg;
    logic [1:0] step_reg;
    logic awr_reg, bval_reg, arr_reg, rval_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdat_reg;
    // ----------------------------------------
    // bus slave decode
    // ----------------------------------------
    // writes stall in awready until the device link is idle
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~awr_reg & ~bval_reg & (st_reg == H_IDLE);
    wire wr_hs = awr_reg & s_axi_awvalid & s_axi_wvalid;
    wire rd_go = s_axi_arvalid & ~arr_reg & ~rval_reg;
    wire rd_hs = arr_reg & s_axi_arvalid;
    wire a_cmd = (s_axi_awaddr == HR_CMD);
    wire a_data = (s_axi_awaddr == HR_DATA);
    wire a_read = (s_axi_awaddr == HR_READ);
    wire a_init = (s_axi_awaddr == HR_INIT);
    wire a_ok = a_cmd | a_data | a_read | a_init;
    wire [31:0] stat = {last_rd_reg, 14'h0000, init_done_reg, (st_reg != H_IDLE) | init_act_reg};
    wire r_ok = (s_axi_araddr == HR_STATUS);
    wire [7:0] init_op = (step_reg == 2'h0) ? OP_MRESET :
                         (step_reg == 2'h1) ? OP_LOAD_ALL : OP_INIT_DP;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            awr_reg <= 1'b0;
            bval_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arr_reg <= 1'b0;
            rval_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdat_reg <= 32'h0000_0000;
        end
        else
        begin
            awr_reg <= wr_go;
            arr_reg <= rd_go;
            if (wr_hs)
            begin
                bval_reg <= 1'b1;
                bresp_reg <= a_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                bval_reg <= 1'b0;
            if (rd_hs)
            begin
                rval_reg <= 1'b1;
                rdat_reg <= r_ok ? stat : 32'h0000_0000;
                rresp_reg <= r_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                rval_reg <= 1'b0;
        end
    end
    // ----------------------------------------
    // device link sequencer
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg <= H_IDLE;
            cd_reg <= 1'b0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            wd_reg <= 16'h0000;
            last_rd_reg <= 16'h0000;
            step_reg <= 2'h0;
            init_act_reg <= 1'b0;
            init_done_reg <= 1'b0;
        end
        else
        begin
            case (st_reg)
                H_IDLE:
                    if (wr_hs & (a_cmd | a_data))
                    begin
                        cd_reg <= a_cmd;
                        wd_reg <= a_cmd ? {8'h00, s_axi_wdata[7:0]} : s_axi_wdata[15:0];
                        wr_reg <= 1'b1;
                        st_reg <= H_WRITE;
                    end
                    else if (wr_hs & a_read)
                    begin
                        cd_reg <= s_axi_wdata[0];
                        rd_reg <= 1'b1;
                        st_reg <= H_READ;
                    end
                    else if (wr_hs & a_init & s_axi_wdata[0])
                    begin
                        step_reg <= 2'h0;
                        init_act_reg <= 1'b1;
                        init_done_reg <= 1'b0;
                        st_reg <= H_INIT;
                    end
                H_INIT:
                begin
                    cd_reg <= 1'b1;
                    wd_reg <= {8'h00, init_op};
                    wr_reg <= 1'b1;
                    step_reg <= step_reg + 2'h1;
                    if (step_reg == 2'h2)
                    begin
                        init_act_reg <= 1'b0;
                        init_done_reg <= 1'b1;
                    end
                    st_reg <= H_WRITE;
                end
                H_WRITE:
                begin
                    wr_reg <= 1'b0;
                    st_reg <= H_WAIT;
                end
                H_WAIT:
                    if (~bus.busy)
                        st_reg <= init_act_reg ? H_INIT : H_IDLE;
                H_READ:
                begin
                    rd_reg <= 1'b0;
                    st_reg <= H_RGAP;
                end
                H_RGAP:
                begin
                    last_rd_reg <= bus.rdata;
                    st_reg <= H_IDLE;
                end
                default:
                    st_reg <= H_IDLE;
            endcase
        end
    end
    assign bus.cd = cd_reg;
    assign bus.wr = wr_reg;
    assign bus.rd = rd_reg;
    assign bus.wdata = wd_reg;
    assign s_axi_awready = awr_reg;
    assign s_axi_wready = awr_reg;
    assign s_axi_bvalid = bval_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arr_reg;
    assign s_axi_rvalid = rval_reg;
    assign s_axi_rdata = rdat_reg;
    assign s_axi_rresp = rresp_reg;
endmodule

// [tb/tcc_chk.sv]
`timescale 1ns/10ps
module tcc_chk
import tcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cd,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic busy
);
    logic pf_reg;
    logic ptr_reg;
    wire take = wr && !busy;
    wire [7:0] op = wdata[7:0];
    // --------------------
    // opcode tracking
    // --------------------
    // pointer survives the master reset command, only the pin clears it
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            pf_reg <= 1'b1;
            ptr_reg <= 1'b0;
        end
        else if (take && cd)
        begin
            pf_reg <= op == OP_PF_DIS ? 1'b0 : (op == OP_PF_EN || op == OP_MRESET) | pf_reg;
            ptr_reg <= ptr_reg | (op[7:5] == 3'h0 && op[2:0] != 3'h0 && op[2:0] != DP_G_BAD);
        end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_take; take |=> busy; endproperty
    a_take: assert property (p_take) else $error("write not taken");
    property p_cmd; take && cd |-> ##40 busy ##1 !busy; endproperty
    a_cmd: assert property (p_cmd) else $error("command recovery");
    property p_dpf; take && !cd && pf_reg |-> ##60 busy ##1 !busy; endproperty
    a_dpf: assert property (p_dpf) else $error("prefetch recovery");
    property p_dnpf; take && !cd && !pf_reg |-> ##40 busy ##1 !busy; endproperty
    a_dnpf: assert property (p_dnpf) else $error("short recovery");
    property p_hold; !$past(rd) |-> $stable(rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_stat; rd && cd |=> rdata[15:6] == 10'h000 && !rdata[0]; endproperty
    a_stat: assert property (p_stat) else $error("status format");
    property p_cause; $rose(busy) |-> $past(wr); endproperty
    a_cause: assert property (p_cause) else $error("busy uncaused");
    property p_ptr; rd && !cd && !ptr_reg |=> rdata == 16'h0000; endproperty
    a_ptr: assert property (p_ptr) else $error("bad pointer read");
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
import tcc_pkg::*;
    logic clk_i = 0, rst_i = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0;
    logic [4:0] src_i = 0, gate_i = 0;
    wire awr, wrr, bv, arr, rv, divided_freq_output, pf;
    wire [4:0] tc;
    wire [1:0] br, rr;
    wire [31:0] rd;
    int n_errors = 0, checks = 0, cyc = 0;
    tcc_if lnk();
    tcc_host i_tcc_host (.clk_i(clk_i), .rst_i(rst_i), .bus(lnk), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy));
    tcc_device i_tcc_device (.clk_i(clk_i), .rst_i(rst_i), .bus(lnk), .src_i(src_i),
        .gate_i(gate_i), .divided_freq_output_o(divided_freq_output), .tc_o(tc), .prefetch_wr_o(pf));
    tcc_chk i_tcc_chk (.clk_i(clk_i), .rst_i(rst_i), .cd(lnk.cd), .wr(lnk.wr), .rd(lnk.rd),
        .wdata(lnk.wdata), .rdata(lnk.rdata), .busy(lnk.busy));
    initial
        forever #12.5 clk_i = ~clk_i;
    // --------------------
    // bus and compare tasks
    // --------------------
    task automatic chk(input logic [31:0] g, e);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        awa <= a; wd <= d; awv <= 1; wv <= 1; brdy <= 1;
        do @(posedge clk_i); while (awr !== 1'b1);
        chk(wrr, 1'b1);
        awv <= 0; wv <= 0;
        while (bv !== 1'b1) @(posedge clk_i);
        r = br; brdy <= 0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        ara <= a; arv <= 1; rrdy <= 1;
        do @(posedge clk_i); while (arr !== 1'b1);
        arv <= 0;
        while (rv !== 1'b1) @(posedge clk_i);
        d = rd; r = rr; rrdy <= 0;
    endtask
    task automatic wr1(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        logic [31:0] s;
        axw(a, d, r);
        chk(r, RESP_OKAY);
        stat(0, s);
    endtask
    task automatic stat(input int b, output logic [31:0] d);
        logic [1:0] r;
        do axr(HR_STATUS, d, r); while (d[b] !== (b == 1));
    endtask
    // tap toggles every clock, divide by one: output high two clocks in four
    task automatic tog(input logic [31:0] e);
        logic [31:0] n;
        n = 32'h0;
        repeat (40) @(posedge clk_i) n += 32'(divided_freq_output);
        chk(n, e);
    endtask
    task automatic rl(input logic c, input logic [15:0] e);
        logic [31:0] s;
        wr1(HR_READ, {31'h0, c});
        stat(0, s);
        chk(s[31:16], e);
    endtask
    task automatic pulse(input int n);
        repeat (n)
        begin
            repeat (6) @(posedge clk_i);
            src_i[0] <= 1'b1;
            repeat (6) @(posedge clk_i);
            src_i[0] <= 1'b0;
        end
    endtask
    // --------------------
    // scenarios
    // --------------------
    task automatic t_init;
        logic [31:0] d;
        logic [1:0] r;
        rl(1'b0, 16'h0000);
        axw(8'h14, 32'h0, r);
        chk(r, RESP_SLVERR);
        axr(8'h14, d, r);
        chk(r, RESP_SLVERR);
        chk(d, 32'h0);
        wr1(HR_INIT, 32'h1);
        stat(1, d);
        chk(d[1:0], 2'h2);
        chk(pf, 1'b1);
        rl(1'b0, CM_RST);
    endtask
    task automatic t_pf;
        wr1(HR_CMD, OP_PF_DIS);
        chk(pf, 1'b0);
        wr1(HR_DATA, OP_MRESET);
        chk(pf, 1'b0);
        wr1(HR_CMD, OP_PF_EN);
        chk(pf, 1'b1);
        wr1(HR_CMD, OP_PF_DIS);
        wr1(HR_CMD, OP_MRESET);
        chk(pf, 1'b1);
    endtask
    task automatic t_divided_freq_output;
        wr1(HR_CMD, 32'h07);
        wr1(HR_DATA, 32'h01B0);
        tog(32'h14);
        wr1(HR_CMD, OP_GATE_OFF);
        tog(32'h0);
        rl(1'b0, 16'h11B0);
        wr1(HR_CMD, OP_GATE_ON);
        rl(1'b0, 16'h01B0);
        tog(32'h14);
    endtask
    task automatic t_cnt;
        wr1(HR_CMD, 32'h09);
        wr1(HR_DATA, 32'h02);
        wr1(HR_CMD, 32'h01);
        wr1(HR_DATA, 32'h2100);
        wr1(HR_CMD, 32'h41);
        wr1(HR_CMD, 32'h21);
        pulse(2);
        rl(1'b1, 16'h0000);
        gate_i[0] <= 1'b1;
        pulse(2);
        rl(1'b1, 16'h0002);
        chk(tc, 5'h01);
        wr1(HR_CMD, OP_MRESET);
        rl(1'b0, CM_RST);
        chk(tc, 5'h00);
    endtask
    task automatic test_done;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // under two thousand cycles expected; the ceiling leaves ample margin
    always @(posedge clk_i)
        if (++cyc == 20000)
        begin
            n_errors++;
            $display("[FAIL] %0t timeout", $time);
            test_done;
        end
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_init;
        t_pf;
        t_divided_freq_output;
        t_cnt;
        test_done;
    end
endmodule
